/* File: pkg/can_filter_pkg.sv */
// constants shared by the mailbox acceptance filter design
package can_filter_pkg;

  // ************************************************************
  // bus geometry
  // ************************************************************
  localparam int          ADDR_W         = 10;
  localparam int          DATA_W         = 32;
  localparam int          BE_W           = 4;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [9:0]  MASK_LOW_OFF   = 10'h000;
  localparam logic [9:0]  MASK_HIGH_OFF  = 10'h004;
  localparam logic [9:0]  MATCH_STAT_OFF = 10'h008;
  localparam logic [9:0]  MB_BASE        = 10'h100;
  localparam logic [9:0]  MB_END         = 10'h300;

  // ************************************************************
  // mailbox storage shape
  // ************************************************************
  localparam int          MB_COUNT       = 16;
  localparam int          MB_BYTES       = 8;
  localparam int          RAM_AW         = 7;
  localparam logic [3:0]  FILTER_MB      = 4'h0;

  // control byte positions, counted from zero (byte 1 is index 0)
  localparam logic [2:0]  CB_LENGTH      = 3'h0;
  localparam logic [2:0]  CB_FORMAT      = 3'h4;
  localparam logic [2:0]  CB_ID_TOP      = 3'h5;
  localparam logic [2:0]  CB_ID_LOW      = 3'h6;
  localparam logic [2:0]  CB_ID_MID      = 3'h7;

  // fields inside the format byte
  localparam int          REMOTE_BIT     = 4;
  localparam int          EXTENDED_BIT   = 3;

  // ************************************************************
  // mask fields and reset values
  // ************************************************************
  localparam logic [15:0] MASK_RESET     = 16'h0000;
  localparam logic [15:0] MASK_HIGH_RW   = 16'hE3FF;
  localparam logic [3:0]  LEN_MAX        = 4'h8;

  // status register fields
  localparam int          STAT_ACCEPT    = 0;
  localparam int          STAT_SEEN      = 1;
  localparam int          STAT_LEN_LSB   = 4;

  // ************************************************************
  // bus handshake states, gray along idle, look, done
  // ************************************************************
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_LOOK = 2'b01,
    BUS_DONE = 2'b11
  } bus_state_t;

endpackage : can_filter_pkg

/* File: core/mailbox_ram.sv */
// byte-wide mailbox control storage, registered read, no reset
`timescale 1ns/10ps
`default_nettype none
module mailbox_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input  wire logic          clock_i,
  input  wire logic          write_i,
  input  wire logic [AW-1:0] address_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_reg [0:(1<<AW)-1];

  // contents are left as power-on garbage on purpose
  always_ff @(posedge clock_i) begin
    if (write_i) begin
      mem_reg[address_i] <= wdata_i;
    end
    rdata_o <= mem_reg[address_i];
  end

endmodule : mailbox_ram
`default_nettype wire

/* File: core/can_mailbox_accept_filter.sv */
// mailbox 0 acceptance filter and mailbox control byte storage
//
// Behaviour
// - low mask bits 15..8 make identifier bits 7..0 don't-care.
// - low mask bits 7..0 make identifier bits 15..8 don't-care.
// - high mask bits 15..13 make identifier bits 20..18 don't-care.
// - high mask bits 9..8 make identifier bits 17..16 don't-care.
// - high mask bits 7..0 make identifier bits 28..21 don't-care.
// - high mask bits 12..10 read as zero and software writes only zero there.
// - the masks act only on mailbox 0 matching and reset to all compared.
// - there are sixteen mailbox sets of eight byte-wide control registers.
// - control storage is a RAM that is never cleared by reset.
// - each control byte 1..8 of every mailbox 0..15 has its own address.
// - byte 1 bits 3..0 are a length code where codes above eight mean eight.
// - byte 5 bit 4 marks a remote frame and bit 3 an extended identifier.
// - the identifier lies in bytes 6, 5, 8 and 7 as laid out for the frame.
`timescale 1ns/10ps
`default_nettype none
module can_mailbox_accept_filter
  import can_filter_pkg::*;
#(
  parameter int MAILBOXES = MB_COUNT
) (
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] address_i,
  input  wire logic              read_i,
  input  wire logic              write_i,
  input  wire logic [DATA_W-1:0] writedata_i,
  input  wire logic [BE_W-1:0]   byteenable_i,
  output logic      [DATA_W-1:0] readdata_o,
  output logic                   waitrequest_o,
  // received identifier from the protocol engine
  input  wire logic              rx_valid_i,
  input  wire logic [28:0]       rx_id_i,
  input  wire logic              rx_extended_i,
  output logic                   rx_done_o,
  output logic                   rx_accept_o,
  output logic      [3:0]        mb0_length_o,
  output logic                   mb0_remote_o,
  output logic                   mb0_extended_o
);

  // ************************************************************
  // functions
  // ************************************************************

  // length code to byte count
  function automatic logic [3:0] clamp_length(input logic [3:0] code);
    clamp_length = (code > LEN_MAX) ? LEN_MAX : code;
  endfunction : clamp_length

  // rebuild the 29-bit identifier from its byte fields
  function automatic logic [28:0] pack_id(
    input logic [7:0] top,
    input logic [7:0] fmt,
    input logic [7:0] mid,
    input logic [7:0] low
  );
    pack_id = {top, fmt[7:5], fmt[1:0], mid, low};
  endfunction : pack_id

  // ************************************************************
  // declarations
  // ************************************************************
  bus_state_t        state_reg;
  bus_state_t        state_next;
  logic [15:0]       mask_low_reg;
  logic [15:0]       mask_high_reg;
  logic [DATA_W-1:0] readdata_reg;
  logic              waitrequest_reg;
  logic              accept_reg;
  logic              done_reg;
  logic              seen_reg;
  logic [7:0]        shadow_reg [0:MB_BYTES-1];

  wire logic              request;
  wire logic              hit_low;
  wire logic              hit_high;
  wire logic              hit_stat;
  wire logic              hit_mb;
  wire logic [ADDR_W-1:0] mb_offset;
  wire logic [RAM_AW-1:0] ram_addr;
  wire logic [3:0]        ram_mailbox;
  wire logic [2:0]        ram_byte;
  wire logic              commit;
  wire logic              ram_we;
  wire logic [7:0]        ram_q;
  wire logic [15:0]       low_next;
  wire logic [15:0]       high_next;
  wire logic [15:0]       high_view;
  wire logic [DATA_W-1:0] stat_view;
  wire logic [DATA_W-1:0] read_mux;
  wire logic [28:0]       dont_care;
  wire logic [28:0]       stored_id;
  wire logic [28:0]       fmt_care;
  wire logic [28:0]       diff;
  wire logic              fmt_match;
  wire logic              id_match;
  wire logic              shadow_we;

  // ************************************************************
  // address decode
  // ************************************************************
  assign request   = read_i | write_i;
  assign hit_low   = (address_i == MASK_LOW_OFF);
  assign hit_high  = (address_i == MASK_HIGH_OFF);
  assign hit_stat  = (address_i == MATCH_STAT_OFF);

  assign hit_mb    = (address_i >= MB_BASE) && (address_i < MB_END);
  assign mb_offset = address_i - MB_BASE;
  assign ram_addr  = mb_offset[RAM_AW+1:2];
  assign ram_mailbox = ram_addr[RAM_AW-1:3];
  assign ram_byte    = ram_addr[2:0];

  // ************************************************************
  // bus handshake
  // ************************************************************

  // writes land on the edge that ends the done cycle
  assign commit = (state_reg == BUS_DONE) && write_i;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BUS_IDLE: begin
        if (request) begin
          state_next = BUS_LOOK;
        end
      end
      BUS_LOOK: begin
        state_next = BUS_DONE;
      end
      BUS_DONE: begin
        state_next = BUS_IDLE;
      end
      default: begin
        state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_reg <= BUS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // wait is dropped for exactly the done cycle
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      waitrequest_reg <= 1'b1;
    end else begin
      waitrequest_reg <= (state_next != BUS_DONE);
    end
  end

  assign waitrequest_o = waitrequest_reg;

  // ************************************************************
  // acceptance masks
  // ************************************************************

  assign low_next = {byteenable_i[1] ? writedata_i[15:8] : mask_low_reg[15:8],
                     byteenable_i[0] ? writedata_i[7:0]  : mask_low_reg[7:0]};

  assign high_next = {byteenable_i[1] ? writedata_i[15:8] : mask_high_reg[15:8],
                      byteenable_i[0] ? writedata_i[7:0]  : mask_high_reg[7:0]}
                     & MASK_HIGH_RW;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mask_low_reg  <= MASK_RESET;
      mask_high_reg <= MASK_RESET;
    end else if (commit && hit_low) begin
      mask_low_reg  <= low_next;
    end else if (commit && hit_high) begin
      mask_high_reg <= high_next;
    end
  end

  assign high_view = mask_high_reg & MASK_HIGH_RW;

  // ************************************************************
  // mailbox control storage
  // ************************************************************

  // only lane 0 carries the byte, upper lanes are dropped
  assign ram_we = commit && hit_mb && byteenable_i[0];

  mailbox_ram #(
    .AW (RAM_AW),
    .DW (8)
  ) u_ram (
    .clock_i   (clock_i),
    .write_i   (ram_we),
    .address_i (ram_addr),
    .wdata_i   (writedata_i[7:0]),
    .rdata_o   (ram_q)
  );

  // mailbox 0 copy so the filter never steals a ram port
  assign shadow_we = ram_we && (ram_mailbox == FILTER_MB);

  genvar gi;
  generate
    for (gi = 0; gi < MB_BYTES; gi++) begin : g_shadow
      // copy follows the ram, also unreset
      always_ff @(posedge clock_i) begin
        if (shadow_we && (ram_byte == 3'(gi))) begin
          shadow_reg[gi] <= writedata_i[7:0];
        end
      end
    end
  endgenerate

  // ************************************************************
  // read data
  // ************************************************************
  assign stat_view = {{(DATA_W-8){1'b0}},
                      clamp_length(shadow_reg[CB_LENGTH][3:0]),
                      2'b00,
                      seen_reg,
                      accept_reg};

  // unmapped words read as zero
  assign read_mux = hit_low  ? {16'h0000, mask_low_reg} :
                    hit_high ? {16'h0000, high_view} :
                    hit_stat ? stat_view :
                    hit_mb   ? {24'h000000, ram_q} :
                               {DATA_W{1'b0}};

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      readdata_reg <= {DATA_W{1'b0}};
    end else if (state_reg == BUS_LOOK) begin
      readdata_reg <= read_i ? read_mux : {DATA_W{1'b0}};
    end
  end

  assign readdata_o = readdata_reg;

  // ************************************************************
  // identifier matching for mailbox 0
  // ************************************************************

  assign stored_id = pack_id(shadow_reg[CB_ID_TOP], shadow_reg[CB_FORMAT],
                             shadow_reg[CB_ID_MID], shadow_reg[CB_ID_LOW]);

  assign dont_care[7:0]   = mask_low_reg[15:8];
  assign dont_care[15:8]  = mask_low_reg[7:0];
  assign dont_care[20:18] = mask_high_reg[15:13];
  assign dont_care[17:16] = mask_high_reg[9:8];
  assign dont_care[28:21] = mask_high_reg[7:0];

  // standard frames use only the top eleven bits
  assign fmt_match = (rx_extended_i == shadow_reg[CB_FORMAT][EXTENDED_BIT]);
  assign fmt_care  = rx_extended_i ? {29{1'b1}} : {{11{1'b1}}, 18'h00000};

  assign diff     = (rx_id_i ^ stored_id) & ~dont_care & fmt_care;
  assign id_match = fmt_match && (diff == 29'h00000000);

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      accept_reg <= 1'b0;
      done_reg   <= 1'b0;
      seen_reg   <= 1'b0;
    end else begin
      done_reg <= rx_valid_i;
      if (rx_valid_i) begin
        accept_reg <= id_match;
        seen_reg   <= 1'b1;
      end
    end
  end

  assign rx_done_o   = done_reg;
  assign rx_accept_o = accept_reg;

  // ************************************************************
  // mailbox 0 frame settings
  // ************************************************************
  logic [3:0] len_reg;
  logic       remote_reg;
  logic       extended_reg;

  // unknown until software fills the bytes, so these stay zero
  // until the first write lands on mailbox 0
  logic       shadow_ok_reg;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      shadow_ok_reg <= 1'b0;
    end else if (shadow_we) begin
      shadow_ok_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i || !shadow_ok_reg) begin
      len_reg      <= 4'h0;
      remote_reg   <= 1'b0;
      extended_reg <= 1'b0;
    end else begin
      len_reg      <= clamp_length(shadow_reg[CB_LENGTH][3:0]);
      remote_reg   <= shadow_reg[CB_FORMAT][REMOTE_BIT];
      extended_reg <= shadow_reg[CB_FORMAT][EXTENDED_BIT];
    end
  end

  assign mb0_length_o   = len_reg;
  assign mb0_remote_o   = remote_reg;
  assign mb0_extended_o = extended_reg;

endmodule : can_mailbox_accept_filter
`default_nettype wire

/* File: test/can_filter_props.sv */
// assertion checker for the mailbox acceptance filter ports
`timescale 1ns/10ps
`default_nettype none
module can_filter_props
  import can_filter_pkg::*;
#(
  parameter int MAILBOXES = MB_COUNT
) (
  input wire logic              clock_i,
  input wire logic              reset_i,
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic              read_i,
  input wire logic              write_i,
  input wire logic [DATA_W-1:0] writedata_i,
  input wire logic [BE_W-1:0]   byteenable_i,
  input wire logic [DATA_W-1:0] readdata_o,
  input wire logic              waitrequest_o,
  input wire logic              rx_valid_i,
  input wire logic [28:0]       rx_id_i,
  input wire logic              rx_extended_i,
  input wire logic              rx_done_o,
  input wire logic              rx_accept_o,
  input wire logic [3:0]        mb0_length_o,
  input wire logic              mb0_remote_o,
  input wire logic              mb0_extended_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence req_take; $rose(read_i || write_i); endsequence
  sequence two_waits; waitrequest_o ##1 !waitrequest_o; endsequence
  sequence read_answer; !waitrequest_o && read_i; endsequence
  bus_latency_a: assert property (req_take |=> two_waits)
    else $error("answer not two cycles after request");
  single_answer_a: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("answer lasted more than one cycle");
  answer_cause_a: assert property (!waitrequest_o |-> read_i || write_i)
    else $error("answer without request");
  reserved_zero_a: assert property (read_answer and address_i == MASK_HIGH_OFF
    |-> readdata_o[12:10] == 3'h0 && readdata_o[31:16] == 16'h0) else $error("reserved mask bits not zero");
  unmapped_zero_a: assert property (read_answer and address_i >= MB_END |-> readdata_o == '0)
    else $error("unmapped read not zero");
  done_pulse_a: assert property (rx_valid_i |=> rx_done_o)
    else $error("compare not answered");
  done_cause_a: assert property (!rx_valid_i |=> !rx_done_o)
    else $error("done without compare");
  accept_hold_a: assert property (!rx_valid_i |=> $stable(rx_accept_o))
    else $error("accept changed without compare");
  length_clamp_a: assert property (mb0_length_o <= LEN_MAX)
    else $error("length above eight");
  reset_state_a: assert property ($past(reset_i) |-> waitrequest_o && readdata_o == '0 && !rx_accept_o)
    else $error("outputs not at reset value");
endmodule : can_filter_props
bind can_mailbox_accept_filter can_filter_props #(.MAILBOXES(MAILBOXES)) u_props (
  .clock_i(clock_i), .reset_i(reset_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
  .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .rx_valid_i(rx_valid_i), .rx_id_i(rx_id_i),
  .rx_extended_i(rx_extended_i), .rx_done_o(rx_done_o), .rx_accept_o(rx_accept_o),
  .mb0_length_o(mb0_length_o), .mb0_remote_o(mb0_remote_o), .mb0_extended_o(mb0_extended_o));
`default_nettype wire

/* File: test/can_frame_source.sv */
// protocol engine stand-in that hands received identifiers to the filter
`timescale 1ns/10ps
`default_nettype none
module can_frame_source (
  input  wire logic        clock_i,
  output logic             rx_valid_o,
  output logic      [28:0] rx_id_o,
  output logic             rx_extended_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_id_o = 29'h0;
    rx_extended_o = 1'b0;
  end
  // outside the pulse the id shows its inverse, never a stale copy
  task automatic send(input logic [28:0] id, input logic ext);
    @(posedge clock_i);
    rx_valid_o <= 1'b1;
    rx_id_o <= id;
    rx_extended_o <= ext;
    @(posedge clock_i);
    rx_valid_o <= 1'b0;
    rx_id_o <= ~id;
    rx_extended_o <= ~ext;
  endtask : send
endmodule : can_frame_source
`default_nettype wire

/* File: test/can_mailbox_accept_filter_bench.sv */
// self-checking bench for the mailbox acceptance filter
`timescale 1ns/10ps
`default_nettype none
module can_mailbox_accept_filter_bench;
  import can_filter_pkg::*;
  logic clock_i, reset_i, bus_read, bus_write, rx_valid, rx_ext, rx_done, rx_accept, remote, extended;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata, rdata;
  logic [BE_W-1:0]   bus_be;
  logic              waitreq;
  logic [28:0]       rx_id, id;
  logic [3:0]        length;
  logic [7:0]        mem [MB_COUNT][MB_BYTES];
  logic [4:0]        mk;
  logic [7:0]        fb;
  logic [31:0]       exp_q[$];
  string             name_q[$];
  int                failures, samples_checked;
  can_mailbox_accept_filter u_dut (.clock_i(clock_i), .reset_i(reset_i), .address_i(bus_addr),
    .read_i(bus_read), .write_i(bus_write), .writedata_i(bus_wdata), .byteenable_i(bus_be),
    .readdata_o(rdata), .waitrequest_o(waitreq), .rx_valid_i(rx_valid), .rx_id_i(rx_id),
    .rx_extended_i(rx_ext), .rx_done_o(rx_done), .rx_accept_o(rx_accept), .mb0_length_o(length),
    .mb0_remote_o(remote), .mb0_extended_o(extended));
  can_frame_source u_src (.clock_i(clock_i), .rx_valid_o(rx_valid), .rx_id_o(rx_id), .rx_extended_o(rx_ext));
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // ****
  // bus master and scoreboard
  // ****
  // no local limit: only the watchdog may end a stuck wait
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge clock_i);
    bus_read <= ~wr;
    bus_write <= wr;
    bus_addr <= a;
    bus_wdata <= d;
    do begin
      @(posedge clock_i);
    end while (waitreq !== 1'b0);
    bus_read <= 1'b0;
    bus_write <= 1'b0;
  endtask : bus
  task automatic rd(input string what, input logic [9:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    name_q.push_back(what);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic frame(input logic [28:0] fid, input logic ext, input logic acc);
    exp_q.push_back({31'h0, acc});
    name_q.push_back("accept");
    u_src.send(fid, ext);
    repeat (2) @(posedge clock_i);
  endtask : frame
  function automatic logic [9:0] mb(input int m, input int k);
    return MB_BASE + 10'(m * 32 + (k - 1) * 4);
  endfunction : mb
  function automatic logic [4:0] mask_pos(input int n);
    if (n < 8) return {1'b0, 4'(n + 8)};
    if (n < 16) return {1'b0, 4'(n - 8)};
    if (n < 18) return {1'b1, 4'(n - 8)};
    if (n < 21) return {1'b1, 4'(n - 5)};
    return {1'b1, 4'(n - 21)};
  endfunction : mask_pos
  always @(posedge clock_i) begin
    if ((bus_read && waitreq === 1'b0) || rx_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("mismatch queue expected an entry seen none");
      end else check(name_q.pop_front(), exp_q.pop_front(), rx_done ? {31'h0, rx_accept} : rdata);
    end
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    results();
  end
  initial begin
    {bus_read, bus_write, bus_addr, bus_wdata} = '0;
    bus_be = 4'hF;
    reset_i = 1'b1;
    void'($urandom(32'h9AC5354B));
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
    rd("mask_low", MASK_LOW_OFF, 32'h0);
    rd("mask_high", MASK_HIGH_OFF, 32'h0);
    bus(1'b1, MASK_LOW_OFF, 32'hFFFF_A5C3);
    rd("mask_low", MASK_LOW_OFF, 32'h0000_A5C3);
    // software keeps the reserved bits at zero
    bus(1'b1, MASK_HIGH_OFF, 32'h0000_E3FF);
    rd("mask_high", MASK_HIGH_OFF, {16'h0, MASK_HIGH_RW});
    bus(1'b1, 10'h30C, 32'h0000_00FF);
    rd("unmapped", 10'h30C, 32'h0);
    $display("test masks done");
    for (int m = 0; m < MB_COUNT; m++)
      for (int k = 1; k <= MB_BYTES; k++) begin
        mem[m][k-1] = 8'($urandom);
        bus(1'b1, mb(m, k), {24'h0, mem[m][k-1]});
      end
    // write without lane 0 must leave the byte alone
    bus_be <= 4'hE;
    bus(1'b1, mb(3, 2), {24'h0, ~mem[3][1]});
    bus_be <= 4'hF;
    for (int m = 0; m < MB_COUNT; m++)
      for (int k = 1; k <= MB_BYTES; k++) rd("mailbox", mb(m, k), {24'h0, mem[m][k-1]});
    // mid-run reset clears the masks but not the storage
    reset_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    reset_i <= 1'b0;
    rd("mask_low_rst", MASK_LOW_OFF, 32'h0);
    rd("mask_high_rst", MASK_HIGH_OFF, 32'h0);
    for (int m = 0; m < MB_COUNT; m++)
      for (int k = 1; k <= MB_BYTES; k++) rd("mailbox_kept", mb(m, k), {24'h0, mem[m][k-1]});
    $display("test mailbox storage done");
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, mb(0, 1), 32'(c));
      repeat (3) @(posedge clock_i);
      check("length", (c > 8) ? 32'h8 : 32'(c), {28'h0, length});
    end
    for (int i = 0; i < 8; i++) begin
      fb = 8'($urandom);
      bus(1'b1, mb(0, 5), {24'h0, fb});
      repeat (3) @(posedge clock_i);
      check("frame_kind", {30'h0, fb[4:3]}, {30'h0, remote, extended});
    end
    $display("test control fields done");
    id = 29'($urandom);
    bus(1'b1, mb(0, 6), {24'h0, id[28:21]});
    bus(1'b1, mb(0, 8), {24'h0, id[15:8]});
    bus(1'b1, mb(0, 7), {24'h0, id[7:0]});
    bus(1'b1, mb(0, 5), {24'h0, id[20:18], 1'b1, 1'b1, 1'b0, id[17:16]});
    for (int k = 0; k < 29; k++) begin
      mk = mask_pos(k);
      bus(1'b1, MASK_LOW_OFF, 32'h0);
      bus(1'b1, MASK_HIGH_OFF, 32'h0);
      frame(id ^ (29'h1 << k), 1'b1, 1'b0);
      bus(1'b1, mk[4] ? MASK_HIGH_OFF : MASK_LOW_OFF, 32'h1 << mk[3:0]);
      frame(id ^ (29'h1 << k), 1'b1, 1'b1);
    end
    bus(1'b1, MASK_HIGH_OFF, 32'h0);
    frame(id, 1'b1, 1'b1);
    frame(id, 1'b0, 1'b0);
    bus(1'b1, mb(0, 5), {24'h0, id[20:18], 5'h0});
    frame(id ^ 29'h3FFFF, 1'b0, 1'b1);
    frame(id ^ 29'h40000, 1'b0, 1'b0);
    // status: clamped length of byte 1 (last 15), seen set, last compare refused
    rd("status", MATCH_STAT_OFF, {24'h0, LEN_MAX, 2'b00, 1'b1, 1'b0});
    $display("test filter done");
    results();
  end
endmodule : can_mailbox_accept_filter_bench
`default_nettype wire
